//--- sdc_pkg.sv
package sdc_pkg;

  localparam int NUM_IN      = 22;
  localparam int NUM_SP      = 8;
  localparam int FRAME_BITS  = 24;
  localparam int SEL_W       = 5;
  localparam int CMD_W       = 8;

  // Command byte, bits 23..16 of a frame
  localparam logic [7:0] CMD_SLEEP    = 8'h0C;
  localparam logic [7:0] CMD_SETTINGS = 8'h01;
  localparam logic [7:0] CMD_WETTING  = 8'h02;
  localparam logic [7:0] CMD_METALLIC = 8'h03;
  localparam logic [7:0] CMD_TRISTATE = 8'h04;
  localparam logic [7:0] CMD_ANALOG   = 8'h05;
  localparam logic [7:0] CMD_STATUS   = 8'h00;

  // Sleep frame fields
  localparam int WAKE_TMR_LSB = 3;
  localparam int SCAN_TMR_LSB = 0;
  localparam int TMR_W        = 3;

  // Analog frame fields
  localparam int ANA_SEL_LSB  = 0;
  localparam int ANA_CUR_LSB  = 5;

  // Reset values
  localparam logic [21:0] RST_TRI     = 22'h3F_FFFF;
  localparam logic [7:0]  RST_POL     = 8'hFF;
  localparam logic [21:0] RST_WET     = 22'h3F_FFFF;
  localparam logic [21:0] RST_HICUR   = 22'h3F_FFFF;
  localparam logic [4:0]  RST_ANA_SEL = 5'h1F;
  localparam logic [4:0]  ANA_NONE    = 5'h1F;

  // Timers: base tick 1 ms, wake period 32 ms << code, scan 1 ms << (code-1)
  localparam int CLK_HZ        = 20000000;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYC      = CLK_HZ / 1000000 * TICK_US;
  localparam int WAKE_BASE_MS  = 32;
  localparam int SCAN_WIN_US   = 125;
  localparam int SCAN_WIN_CYC  = CLK_HZ / 1000000 * SCAN_WIN_US;

  typedef enum logic [1:0] {
    SDC_NORMAL = 2'b00,
    SDC_SLEEP  = 2'b01,
    SDC_SCAN   = 2'b10
  } sdc_mode_t;

  typedef enum logic [1:0] {
    SDC_ANA_HIZ  = 2'b00,
    SDC_ANA_LO   = 2'b01,
    SDC_ANA_HI   = 2'b10
  } sdc_ana_cur_t;

  typedef struct packed {
    logic [21:0] triState;
    logic [7:0]  polGnd;
    logic [21:0] wetEn;
    logic [21:0] hiCur;
  } sdc_cfg_t;

  typedef struct packed {
    logic [21:0] srcOn;
    logic [21:0] sinkOn;
    logic [21:0] hiCur;
  } sdc_drive_t;

endpackage

//--- sdc_sync.sv
`timescale 1ns/1ps
module sdc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sdc_sync_t;

  sdc_sync_t st;
  sdc_sync_t next_st;

  always_comb
  begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_sys)
  begin
    // Reset loads the pin level so no false edge follows release
    if (!rstn)
      st <= {d, d};
    else
      st <= next_st;
  end

  assign q = st.s2;
endmodule // sdc_sync

//--- sdc_timer.sv
`timescale 1ns/1ps
module sdc_timer (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [2:0] code,
  input  wire logic       isWake,
  output logic            expire
);
  typedef struct packed {
    logic [15:0] tick;
    logic [12:0] ms;
    logic        expire;
  } sdc_tmr_t;

  sdc_tmr_t st;
  sdc_tmr_t next_st;
  logic [12:0] limit;

  always_comb
  begin
    if (isWake)
      limit = 13'(sdc_pkg::WAKE_BASE_MS << code);
    else
      limit = (code == 3'h0) ? 13'h0000 : 13'(1 << (code - 3'h1));
  end

  always_comb
  begin
    next_st = st;
    next_st.expire = 1'b0;
    // Held in reset while run is low, and for the scan timer with code 0: no stale count leaks into the next nap
    if (!run || (!isWake && code == 3'h0))
    begin
      next_st.tick = '0;
      next_st.ms = '0;
    end
    else if (st.tick == 16'(sdc_pkg::TICK_CYC - 1))
    begin
      next_st.tick = '0;
      if (st.ms + 13'h0001 >= limit)
      begin
        next_st.ms = '0;
        next_st.expire = 1'b1;
      end
      else
        next_st.ms = st.ms + 13'h0001;
    end
    else
      next_st.tick = st.tick + 16'h0001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign expire = st.expire;
endmodule // sdc_timer

//--- sdc_switch_detect.sv
`timescale 1ns/1ps
// Function
// - One of 22 inputs routed to analog output by binary code in analog command.
// - Analog selector changes only at the chip select rise ending the frame.
// - The analog-selected input reads 0 in following serial status words.
// - Analog input current selectable: high impedance, 2.0 mA or 16 mA.
// - After reset Normal mode with every input tri-stated.
// - Programmable inputs source or sink according to polarity setting.
// - Battery-polarity programmable input out of tri-state pulls pin low.
// - Ground polarity sources current; battery polarity sinks current.
// - Tri-stated ground-switch input held low reports 1 in status.
// - Ground switch out of tri-state sources current; tri-state turns it off.
// - Configuration commands accepted in Normal mode; host sends them there.
// - No serial wake-up while logic supply is absent.
// - Falling chip select with logic supply present returns device from Sleep to Normal; ignored in Scan.
// - Parallel devices are selected independently and sleep one after another.
// - Sleep command takes effect at the chip select rise ending the frame.
// - Wake line high in Sleep mode, low in Normal and Scan modes; falling wake line wakes device.
// - Switch change during sleep frame keeps device out of Sleep mode.
// - Supply-monitor reset gives Normal mode with default registers.
// - Sleep frame bits 5..3 wake interval, bits 2..0 scan interval.
// - Sleep exits on switch change, timer, wake or interrupt fall, chip select, reset.
// - Wake-up and scan timers inactive in Normal mode.
module sdc_switch_detect (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        spiClk,
  input  wire logic        chipSelN,
  input  wire logic        serialIn,
  output logic             serialOut,
  input  wire logic        logicSupplyOk,
  input  wire logic [21:0] switchIn,
  input  wire logic        wakeIn,
  output logic             wakeOut,
  output logic             wakeOutEn,
  input  wire logic        irqIn,
  output logic             irqOutN,
  output logic [4:0]       analogSelect,
  output logic [1:0]       analogCurrent,
  output sdc_pkg::sdc_drive_t drive,
  output logic             sleeping
);
  typedef struct packed {
    logic                  sclkD;
    logic                  csD;
    logic                  wakeD;
    logic                  irqD;
    logic [23:0]           shiftIn;
    logic [23:0]           shiftOut;
    logic                  so;
    logic                  swChg;
    sdc_pkg::sdc_mode_t    mode;
    sdc_pkg::sdc_cfg_t     cfg;
    logic [4:0]            anaSel;
    logic [1:0]            anaCur;
    logic [2:0]            wakeCode;
    logic [2:0]            scanCode;
    logic [21:0]           sleepRef;
    logic [11:0]           scanCnt;
    logic                  irq;
  } sdc_state_t;

  sdc_state_t st;
  sdc_state_t next_st;
  logic [27:0] synIn;
  logic [21:0] sw;
  logic sclk, cs, wk, irqPin;
  logic sin, supOk;
  logic wakeExp, scanExp;
  logic [21:0] status;

  // Data and supply ride with the clock so they stay aligned to its edges
  sdc_sync #(.W(28)) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       ({spiClk, chipSelN, wakeIn, irqIn, serialIn, logicSupplyOk, switchIn}),
    .q       (synIn)
  );
  assign {sclk, cs, wk, irqPin, sin, supOk, sw} = synIn;

  sdc_timer u_wake (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (st.mode != sdc_pkg::SDC_NORMAL),
    .code    (st.wakeCode),
    .isWake  (1'b1),
    .expire  (wakeExp)
  );

  sdc_timer u_scan (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (st.mode == sdc_pkg::SDC_SLEEP),
    .code    (st.scanCode),
    .isWake  (1'b0),
    .expire  (scanExp)
  );

  // Status: closed switch reads 1; analog channel masked
  function automatic logic [21:0] statusWord(input logic [21:0] pins, input logic [7:0] polGnd,
                                              input logic [4:0] sel);
    logic [21:0] w;
    w = ~pins;
    for (int i = 0; i < sdc_pkg::NUM_SP; i++)
      if (!polGnd[i])
        w[i] = pins[i];
    if (sel < 5'(sdc_pkg::NUM_IN))
      w[sel] = 1'b0;
    return w;
  endfunction

  assign status = statusWord(sw, st.cfg.polGnd, st.anaSel);

  always_comb
  begin
    logic sRise, sFall, csRise, csFall;
    logic [7:0] cmd;
    logic [23:0] fr;
    sRise = sclk && !st.sclkD;
    sFall = !sclk && st.sclkD;
    csRise = cs && !st.csD;
    csFall = !cs && st.csD;
    next_st = st;
    next_st.sclkD = sclk;
    next_st.csD = cs;
    next_st.wakeD = wk;
    next_st.irqD = irqPin;
    fr = st.shiftIn;
    cmd = fr[23:16];
    if (csFall)
    begin
      next_st.shiftOut = {2'b00, status};
      // Reply bit 23 is always 0: it stands before the first clock
      next_st.so = 1'b0;
      next_st.swChg = 1'b0;
    end
    else if (!cs && sRise)
    begin
      next_st.shiftIn = {st.shiftIn[22:0], sin};
      // Received bits follow the reply out, so chained parts act as one register
      next_st.shiftOut = {st.shiftOut[22:0], sin};
    end
    else if (!cs && sFall)
      next_st.so = st.shiftOut[23];
    // Change seen while the frame shifts blocks a sleep entry
    if (!cs && status != statusWord(st.sleepRef, st.cfg.polGnd, st.anaSel) && !csFall)
      next_st.swChg = 1'b1;
    if (csFall || st.mode == sdc_pkg::SDC_NORMAL)
      next_st.sleepRef = sw;
    case (st.mode)
      sdc_pkg::SDC_NORMAL:
      begin
        if (csRise)
        begin
          if (cmd == sdc_pkg::CMD_SLEEP && !st.swChg)
          begin
            next_st.mode = sdc_pkg::SDC_SLEEP;
            next_st.wakeCode = fr[sdc_pkg::WAKE_TMR_LSB +: sdc_pkg::TMR_W];
            next_st.scanCode = fr[sdc_pkg::SCAN_TMR_LSB +: sdc_pkg::TMR_W];
          end
          else if (cmd == sdc_pkg::CMD_SETTINGS)
            next_st.cfg.polGnd = fr[7:0];
          else if (cmd == sdc_pkg::CMD_WETTING)
            next_st.cfg.wetEn = fr[21:0];
          else if (cmd == sdc_pkg::CMD_METALLIC)
            next_st.cfg.hiCur = fr[21:0];
          else if (cmd == sdc_pkg::CMD_TRISTATE)
            next_st.cfg.triState = fr[21:0];
          else if (cmd == sdc_pkg::CMD_ANALOG)
          begin
            next_st.anaSel = fr[sdc_pkg::ANA_SEL_LSB +: sdc_pkg::SEL_W];
            next_st.anaCur = fr[sdc_pkg::ANA_CUR_LSB +: 2];
          end
        end
      end
      sdc_pkg::SDC_SLEEP:
      begin
        if (wakeExp || (!wk && st.wakeD) || (supOk && csFall)
            || (supOk && wk && !irqPin && st.irqD))
          next_st.mode = sdc_pkg::SDC_NORMAL;
        else if (scanExp)
        begin
          next_st.mode = sdc_pkg::SDC_SCAN;
          next_st.scanCnt = '0;
        end
      end
      sdc_pkg::SDC_SCAN:
      begin
        // Short window lets inputs settle before compare
        if (st.scanCnt == 12'(sdc_pkg::SCAN_WIN_CYC - 1))
          next_st.mode = (sw != st.sleepRef) ? sdc_pkg::SDC_NORMAL : sdc_pkg::SDC_SLEEP;
        else if (wakeExp || (!wk && st.wakeD))
          next_st.mode = sdc_pkg::SDC_NORMAL;
        else
          next_st.scanCnt = st.scanCnt + 12'h001;
      end
      default: next_st.mode = sdc_pkg::SDC_NORMAL;
    endcase
    next_st.irq = (st.mode != sdc_pkg::SDC_NORMAL) && (next_st.mode == sdc_pkg::SDC_NORMAL);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.sclkD <= 1'b0;
      st.csD <= 1'b1;
      // Own pin holds the wake line low while awake
      st.wakeD <= 1'b0;
      st.irqD <= 1'b1;
      st.mode <= sdc_pkg::SDC_NORMAL;
      st.cfg.triState <= sdc_pkg::RST_TRI;
      st.cfg.polGnd <= sdc_pkg::RST_POL;
      st.cfg.wetEn <= sdc_pkg::RST_WET;
      st.cfg.hiCur <= sdc_pkg::RST_HICUR;
      st.anaSel <= sdc_pkg::RST_ANA_SEL;
    end
    else
      st <= next_st;
  end

  // Drivers: scan window drives like Normal so inputs behave as programmed
  genvar g;
  generate
    for (g = 0; g < sdc_pkg::NUM_IN; g++)
    begin : g_drv
      logic act, ana;
      assign ana = (st.anaSel == 5'(g));
      assign act = (st.mode != sdc_pkg::SDC_SLEEP) && !st.cfg.triState[g];
      if (g < sdc_pkg::NUM_SP)
      begin : g_sp
        assign drive.srcOn[g] = ana ? (st.anaCur != 2'b00) : (act && st.cfg.polGnd[g]);
        assign drive.sinkOn[g] = !ana && act && !st.cfg.polGnd[g];
      end
      else
      begin : g_sg
        assign drive.srcOn[g] = ana ? (st.anaCur != 2'b00) : act;
        assign drive.sinkOn[g] = 1'b0;
      end
      assign drive.hiCur[g] = ana ? (st.anaCur == 2'b10) : st.cfg.hiCur[g];
    end
  endgenerate

  assign serialOut     = st.so;
  assign sleeping      = st.mode == sdc_pkg::SDC_SLEEP;
  assign wakeOut       = 1'b0;
  assign wakeOutEn     = (st.mode == sdc_pkg::SDC_SLEEP);
  assign irqOutN       = !st.irq;
  assign analogSelect  = st.anaSel;
  assign analogCurrent = st.anaCur;

  property p_sleep_entry;
    @(posedge clk_sys) disable iff (!rstn)
      (st.mode == sdc_pkg::SDC_NORMAL && next_st.mode == sdc_pkg::SDC_SLEEP) |-> (cs && !st.csD);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep entered off chip select rise");

  property p_ana_change;
    @(posedge clk_sys) disable iff (!rstn)
      $changed(st.anaSel) |-> $past(cs && !st.csD);
  endproperty
  a_ana_change: assert property (p_ana_change) else $error("Analog select moved off frame end");

  property p_status_mask;
    @(posedge clk_sys) disable iff (!rstn)
      (st.anaSel < 5'd22) |-> status[st.anaSel] == 1'b0;
  endproperty
  a_status_mask: assert property (p_status_mask) else $error("Analog input status not zero");

  property p_timers_idle;
    @(posedge clk_sys) disable iff (!rstn)
      (st.mode == sdc_pkg::SDC_NORMAL) ##1 (st.mode == sdc_pkg::SDC_NORMAL) |-> !wakeExp && !scanExp;
  endproperty
  a_timers_idle: assert property (p_timers_idle) else $error("Timer fired in Normal mode");

  property p_wake_pin;
    @(posedge clk_sys) disable iff (!rstn)
      wakeOutEn == (st.mode == sdc_pkg::SDC_SLEEP) && wakeOut == 1'b0;
  endproperty
  a_wake_pin: assert property (p_wake_pin) else $error("Wake line wrong for mode");

  property p_no_spi_wake;
    @(posedge clk_sys) disable iff (!rstn)
      (st.mode == sdc_pkg::SDC_SLEEP && !supOk && wk && !wakeExp && !scanExp)
        |=> st.mode == sdc_pkg::SDC_SLEEP;
  endproperty
  a_no_spi_wake: assert property (p_no_spi_wake) else $error("Woke without supply");

  property p_cs_wake;
    @(posedge clk_sys) disable iff (!rstn)
      (st.mode == sdc_pkg::SDC_SLEEP && supOk && !cs && st.csD) |=> st.mode == sdc_pkg::SDC_NORMAL;
  endproperty
  a_cs_wake: assert property (p_cs_wake) else $error("Chip select fall did not wake");

  property p_race;
    @(posedge clk_sys) disable iff (!rstn)
      (st.mode == sdc_pkg::SDC_NORMAL && st.swChg && cs && !st.csD) |=> st.mode != sdc_pkg::SDC_SLEEP;
  endproperty
  a_race: assert property (p_race) else $error("Slept despite switch change");

  property p_reset_tri;
    @(posedge clk_sys) $rose(rstn) |-> st.cfg.triState == sdc_pkg::RST_TRI && st.mode == sdc_pkg::SDC_NORMAL;
  endproperty
  a_reset_tri: assert property (p_reset_tri) else $error("Reset state wrong");
endmodule // sdc_switch_detect

//--- sdc_host.sv
`timescale 1ns/1ps
module sdc_host (
  input  wire logic clk_sys,
  output logic      spiClk,
  output logic      chipSelN,
  output logic      serialIn,
  input  wire logic serialOut
);

  // Serial clock stands low outside frames
  initial
  begin
    spiClk   = 1'b0;
    chipSelN = 1'b1;
    serialIn = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Ends a frame; released data line shows the inverse so nothing stale passes
  task automatic close();
    chipSelN = 1'b1;
    serialIn = ~serialIn;
    idle(8);
  endtask

  // MSB first; host samples on rise, changes data after fall
  task automatic xfer(input logic [47:0] tx, input int n, input bit keepOpen, output logic [47:0] rx);
    rx = '0;
    @(negedge clk_sys);
    chipSelN = 1'b0;
    idle(8);
    for (int i = n - 1; i >= 0; i--)
    begin
      serialIn = tx[i];
      idle(4);
      rx = {rx[46:0], serialOut};
      spiClk = 1'b1;
      idle(4);
      spiClk = 1'b0;
    end
    idle(4);
    if (!keepOpen)
      close();
  endtask

endmodule // sdc_host

//--- sdc_switch_detect_tb_top.sv
`timescale 1ns/1ps
module sdc_switch_detect_tb_top;

  logic                clk_sys;
  logic                rstn;
  logic                spiClk;
  logic                chipSelN;
  logic                serialIn;
  logic                serialOut;
  logic                logicSupplyOk;
  logic [21:0]         switchIn;
  logic                extWakeN;
  logic                extIrqN;
  logic                wakeLine;
  logic                irqLine;
  logic                wakeOut;
  logic                wakeOutEn;
  logic                irqOutN;
  logic [4:0]          analogSelect;
  logic [1:0]          analogCurrent;
  sdc_pkg::sdc_drive_t drive;
  logic                sleeping;
  int                  bad_count;
  int                  checks;
  int                  irqLow;
  int                  mIrq;
  logic [7:0]          mPol;
  logic [21:0]         mTri;
  logic [21:0]         mHi;
  logic [4:0]          mSel;
  logic [47:0]         rx;
  logic [47:0]         tx;

  // Wake line pulled up when released; irq line wired-and
  assign wakeLine = (wakeOutEn ? 1'b1 : wakeOut) & extWakeN;
  assign irqLine  = irqOutN & extIrqN;

  sdc_switch_detect uut (
    .clk_sys       (clk_sys),
    .rstn          (rstn),
    .spiClk        (spiClk),
    .chipSelN      (chipSelN),
    .serialIn      (serialIn),
    .serialOut     (serialOut),
    .logicSupplyOk (logicSupplyOk),
    .switchIn      (switchIn),
    .wakeIn        (wakeLine),
    .wakeOut       (wakeOut),
    .wakeOutEn     (wakeOutEn),
    .irqIn         (irqLine),
    .irqOutN       (irqOutN),
    .analogSelect  (analogSelect),
    .analogCurrent (analogCurrent),
    .drive         (drive),
    .sleeping      (sleeping)
  );

  sdc_host uHost (
    .clk_sys   (clk_sys),
    .spiClk    (spiClk),
    .chipSelN  (chipSelN),
    .serialIn  (serialIn),
    .serialOut (serialOut)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (irqOutN === 1'b0)
      irqLow <= irqLow + 1;

  task automatic finish_test();
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] c, input logic [15:0] d);
    uHost.xfer({24'h00_0000, c, d}, 24, 1'b0, rx);
  endtask

  // Closed reads 1; battery-polarity inputs read the pin level
  function automatic logic [21:0] expStat(input logic [21:0] pins);
    logic [21:0] s;
    s = ~pins;
    for (int i = 0; i < 8; i++)
      if (!mPol[i])
        s[i] = pins[i];
    if (mSel < 5'd22)
      s[mSel] = 1'b0;
    return s;
  endfunction

  task automatic readStatus();
    cmd(sdc_pkg::CMD_STATUS, 16'h0000);
    check(rx[21:0], expStat(switchIn));
  endtask

  // Only the low sixteen inputs are reachable from one frame's payload
  task automatic checkDrive();
    logic [21:0] m;
    m = 22'h00_FFFF;
    check(drive.srcOn & m, ~mTri & m & (22'h3F_FF00 | {14'h0000, mPol}));
    check(drive.sinkOn & m, ~mTri & m & ~(22'h3F_FF00 | {14'h0000, mPol}));
    check(drive.hiCur & ~mTri & m, mHi & ~mTri & m);
  endtask

  task automatic doReset();
    @(negedge clk_sys);
    rstn = 1'b0;
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    mTri = sdc_pkg::RST_TRI;
    mPol = sdc_pkg::RST_POL;
    mHi  = sdc_pkg::RST_HICUR;
    mSel = sdc_pkg::ANA_NONE;
    repeat (4) @(negedge clk_sys);
    check({sleeping, wakeOutEn, irqOutN, analogSelect}, {3'b001, 5'h1F});
    check(drive.srcOn | drive.sinkOn, 22'h00_0000);
  endtask

  task automatic goSleep();
    uHost.xfer({24'h00_0000, sdc_pkg::CMD_SLEEP, 16'h0038}, 24, 1'b1, rx);
    check(sleeping, 1'b0);
    uHost.close();
    check({sleeping, wakeOutEn, wakeLine}, 3'b111);
  endtask

  task automatic woke();
    repeat (8) @(negedge clk_sys);
    mIrq++;
    check({sleeping, wakeOutEn}, 2'b00);
    check(irqLow, mIrq);
  endtask

  initial
  begin
    rstn = 1'b0;
    logicSupplyOk = 1'b1;
    switchIn = 22'h00_0000;
    extWakeN = 1'b1;
    extIrqN = 1'b1;
    bad_count = 0;
    checks = 0;
    irqLow = 0;
    mIrq = 0;
    void'($urandom(32'h0000_9D86));
    doReset();
    // Gate drive setup in host order, then toggle polarity
    for (int k = 0; k < 4; k++)
    begin
      mHi[15:0] = 16'($urandom);
      mPol = 8'($urandom);
      mTri[15:0] = 16'($urandom);
      cmd(sdc_pkg::CMD_WETTING, 16'h0000);
      cmd(sdc_pkg::CMD_METALLIC, mHi[15:0]);
      cmd(sdc_pkg::CMD_SETTINGS, {8'h00, mPol});
      cmd(sdc_pkg::CMD_TRISTATE, mTri[15:0]);
      @(negedge clk_sys);
      switchIn = 22'($urandom);
      checkDrive();
      readStatus();
      mPol = ~mPol;
      cmd(sdc_pkg::CMD_SETTINGS, {8'h00, mPol});
      checkDrive();
    end
    // Sleep, refused config with supply off, wake by wake line
    goSleep();
    logicSupplyOk = 1'b0;
    cmd(sdc_pkg::CMD_SETTINGS, {8'h00, ~mPol});
    check(sleeping, 1'b1);
    logicSupplyOk = 1'b1;
    extWakeN = 1'b0;
    woke();
    extWakeN = 1'b1;
    checkDrive();
    goSleep();
    cmd(sdc_pkg::CMD_STATUS, 16'h0000);
    woke();
    goSleep();
    extIrqN = 1'b0;
    woke();
    extIrqN = 1'b1;
    // Scan poll after 1 ms drops the wake line, whose fall wakes the device
    uHost.xfer({24'h00_0000, sdc_pkg::CMD_SLEEP, 16'h0039}, 24, 1'b0, rx);
    switchIn[3] = ~switchIn[3];
    repeat (19000) @(negedge clk_sys);
    check(sleeping, 1'b1);
    repeat (4000) @(negedge clk_sys);
    woke();
    // Switch change while sleep frame shifts
    fork
      uHost.xfer({24'h00_0000, sdc_pkg::CMD_SLEEP, 16'h0038}, 24, 1'b0, rx);
      begin
        repeat (100) @(negedge clk_sys);
        switchIn[9] = ~switchIn[9];
      end
    join
    check({sleeping, wakeOutEn}, 2'b00);
    check(irqLow, mIrq);
    cmd(sdc_pkg::CMD_STATUS, 16'h0000);
    readStatus();
    // Analog selection, every current setting
    for (int c = 0; c < 3; c++)
    begin
      tx[4:0] = 5'($urandom_range(21, 0));
      uHost.xfer({24'h00_0000, sdc_pkg::CMD_ANALOG, 9'h000, 2'(c), tx[4:0]}, 24, 1'b1, rx);
      check(analogSelect, mSel);
      uHost.close();
      mSel = tx[4:0];
      check({analogCurrent, analogSelect}, {2'(c), mSel});
      check({drive.srcOn[mSel], drive.hiCur[mSel]}, {c != 0, c == 2});
      switchIn[mSel] = ~switchIn[mSel];
      readStatus();
    end
    // Two chained frames: first 24 bits emerge after the status word
    tx = {24'($urandom), sdc_pkg::CMD_STATUS, 16'h0000};
    uHost.xfer(tx, 48, 1'b0, rx);
    check(rx[23:0], tx[47:24]);
    check(rx[45:24], expStat(switchIn));
    goSleep();
    doReset();
    // Silent reset undoes the drive setup until the host rewrites it
    mTri[15:0] = 16'h0000;
    cmd(sdc_pkg::CMD_TRISTATE, mTri[15:0]);
    checkDrive();
    finish_test();
  end

  initial
  begin
    #4_000_000;
    bad_count++;
    finish_test();
  end

endmodule // sdc_switch_detect_tb_top
